// ---- icm_pkg.sv ----
// Package with constants and types for the interrupt channel mapper.
`default_nettype none

package icm_pkg;

  // Bus widths.
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int STRB_W = DATA_W / 8;

  // Selector and channel geometry.
  localparam int SEL_W  = 5;
  localparam int LANE_W = 8;
  localparam int LANES  = 4;
  localparam int NUM_CH = 32;

  // Covered request inputs.
  localparam int FIRST_IN = 9;
  localparam int LAST_IN  = 27;
  localparam int NUM_IN   = LAST_IN - FIRST_IN + 1;

  // Routing words that hold covered selectors.
  localparam int FIRST_WORD = FIRST_IN / LANES;
  localparam int LAST_WORD  = LAST_IN / LANES;

  // Register offsets.
  localparam logic [ADDR_W-1:0] PEND_OFFSET      = 12'h000;
  localparam logic [ADDR_W-1:0] CHAN_STAT_OFFSET = 12'h010;
  localparam logic [ADDR_W-1:0] WORD_BASE        = 12'h020;
  localparam int                WORD_STRIDE      = 4;

  // Privilege flag position in the protection field.
  localparam int PRIV_BIT = 0;

  // Selector reset codes, index 0 is input 9, index 18 is input 27.
  localparam logic [NUM_IN-1:0][SEL_W-1:0] SEL_RESET = '{
    5'h1b, 5'h1a, 5'h19, 5'h18,
    5'h17, 5'h16, 5'h15, 5'h14,
    5'h13, 5'h12, 5'h11, 5'h10,
    5'h0f, 5'h0e, 5'h0d, 5'h0c,
    5'h0b, 5'h0a, 5'h09};

  // Request half of an APB transfer.
  typedef struct packed {
    logic [ADDR_W-1:0] paddr;
    logic              pwrite;
    logic [DATA_W-1:0] pwdata;
    logic [STRB_W-1:0] pstrb;
    logic [2:0]        pprot;
  } icm_apb_req_t;

  // Byte address of a routing word.
  function automatic logic [ADDR_W-1:0] word_addr(input int w);
    word_addr = WORD_BASE + ADDR_W'(w * WORD_STRIDE);
  endfunction

endpackage

`default_nettype wire

// ---- icm_route_field.sv ----
// One five-bit routing selector held in its own byte lane.
`default_nettype none

module icm_route_field #(
  parameter logic [icm_pkg::SEL_W-1:0] RESET_VAL = '0
) (
  // Clock and reset.
  input  wire logic                        clock_i,
  input  wire logic                        reset_n_i,
  // Byte write.
  input  wire logic                        wr_en_i,
  input  wire logic [icm_pkg::LANE_W-1:0]  wr_byte_i,
  // Current selector.
  output logic      [icm_pkg::SEL_W-1:0]   sel_o
);

  // Only the low five bits of the lane are stored; the rest are dropped.
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      sel_o <= RESET_VAL;
    end
    else if (wr_en_i)
    begin
      sel_o <= wr_byte_i[icm_pkg::SEL_W-1:0];
    end
  end

endmodule

`default_nettype wire

// ---- icm_interrupt_channel_mapper.sv ----
// Interrupt channel mapper for request inputs 9 to 27 with APB registers.
//
// Function
// - Each covered input has a five-bit selector naming channel 0 to 31.
// - Selectors change only on privileged writes; software must be privileged.
// - Byte writes change only the addressed lane's selector.
// - Bits 31:29, 23:21, 15:13, 7:5 read unspecified and ignore writes.
// - Four selectors per word, lowest input in 28:24, then 20:16, 12:8, 4:0.
// - Inputs 10 and 11 reset to channels 10 and 11.
// - Inputs 12, 14, 15 reset to channels 12, 14, 15.
// - Inputs 16, 18, 19 reset to channels 16, 18, 19.
// - Inputs 20, 22, 23 reset to channels 20, 22, 23.
// - Input 24 resets to channel 24; inputs 26, 27 to 26, 27.
// - A pending flag per input shows whether its peripheral requested in the previous cycle.
//
// The placing of the registers and the APB register port are this design's own decisions.
`default_nettype none

module icm_interrupt_channel_mapper (
  // Clock and reset.
  input  wire logic                          clock_i,
  input  wire logic                          reset_n_i,
  // APB slave.
  input  wire logic                          psel_i,
  input  wire logic                          penable_i,
  input  wire icm_pkg::icm_apb_req_t         req_i,
  output logic      [icm_pkg::DATA_W-1:0]    prdata_o,
  output logic                               pready_o,
  output logic                               pslverr_o,
  // Peripheral requests, bit 0 is input 9.
  input  wire logic [icm_pkg::NUM_IN-1:0]    periph_req_i,
  // Central controller channels and pending flags.
  output logic      [icm_pkg::NUM_CH-1:0]    channel_req_out_o,
  output logic      [icm_pkg::NUM_IN-1:0]    input_pending_flags_o
);

  // Selector storage and per-field write enables.
  logic [icm_pkg::SEL_W-1:0]  route_sel [icm_pkg::NUM_IN];
  logic [icm_pkg::NUM_IN-1:0] field_wr_en;

  // Assembled routing words for readback.
  logic [icm_pkg::DATA_W-1:0]
    word_img [icm_pkg::FIRST_WORD:icm_pkg::LAST_WORD];

  // Bus phase decode.
  logic setup_phase;
  logic access_fire;
  logic priv_write;
  logic word_hit;
  logic ro_hit;

  // Next values for the registered outputs.
  logic [icm_pkg::DATA_W-1:0] next_prdata;
  logic                       next_pslverr;
  logic [icm_pkg::NUM_CH-1:0] next_channel_req;

  // Phases of the transfer; the answer comes in the first access cycle.
  assign setup_phase = psel_i && !penable_i;
  assign access_fire = psel_i && penable_i;
  assign pready_o    = access_fire;

  assign priv_write = access_fire && req_i.pwrite
                      && req_i.pprot[icm_pkg::PRIV_BIT];

  // One selector per covered input, each in its own byte lane.
  genvar gi;
  generate
    for (gi = 0; gi < icm_pkg::NUM_IN; gi++)
    begin : g_field
      localparam int IN_NUM = icm_pkg::FIRST_IN + gi;
      localparam int WORD   = IN_NUM / icm_pkg::LANES;
      localparam int LANE   = icm_pkg::LANES - 1
                              - (IN_NUM % icm_pkg::LANES);

      assign field_wr_en[gi] = priv_write
          && (req_i.paddr == icm_pkg::word_addr(WORD))
          && req_i.pstrb[LANE];

      icm_route_field #(
        .RESET_VAL (icm_pkg::SEL_RESET[gi])
      ) u_field (
        .clock_i   (clock_i),
        .reset_n_i (reset_n_i),
        .wr_en_i   (field_wr_en[gi]),
        .wr_byte_i (req_i.pwdata[LANE*icm_pkg::LANE_W +: icm_pkg::LANE_W]),
        .sel_o     (route_sel[gi])
      );
    end
  endgenerate

  // Readback images; reserved bits and the uncovered lane read as zero.
  always_comb
  begin
    for (int w = icm_pkg::FIRST_WORD; w <= icm_pkg::LAST_WORD; w++)
    begin
      word_img[w] = '0;
    end
    for (int i = 0; i < icm_pkg::NUM_IN; i++)
    begin
      word_img[(icm_pkg::FIRST_IN + i) / icm_pkg::LANES]
              [(icm_pkg::LANES - 1 - (icm_pkg::FIRST_IN + i)
                % icm_pkg::LANES) * icm_pkg::LANE_W +: icm_pkg::SEL_W]
        = route_sel[i];
    end
  end

  // Address decode for routing words and read-only status words.
  always_comb
  begin
    word_hit = 1'b0;
    for (int w = icm_pkg::FIRST_WORD; w <= icm_pkg::LAST_WORD; w++)
    begin
      if (req_i.paddr == icm_pkg::word_addr(w))
      begin
        word_hit = 1'b1;
      end
    end
    ro_hit = (req_i.paddr == icm_pkg::PEND_OFFSET)
             || (req_i.paddr == icm_pkg::CHAN_STAT_OFFSET);
  end

  // Read data and error answer, prepared during the setup cycle.
  always_comb
  begin
    next_prdata  = '0;
    next_pslverr = 1'b0;
    if (req_i.paddr == icm_pkg::PEND_OFFSET)
    begin
      next_prdata[icm_pkg::FIRST_IN +: icm_pkg::NUM_IN] =
        input_pending_flags_o;
    end
    else if (req_i.paddr == icm_pkg::CHAN_STAT_OFFSET)
    begin
      next_prdata = channel_req_out_o;
    end
    else if (word_hit)
    begin
      for (int w = icm_pkg::FIRST_WORD; w <= icm_pkg::LAST_WORD; w++)
      begin
        if (req_i.paddr == icm_pkg::word_addr(w))
        begin
          next_prdata = word_img[w];
        end
      end
      if (req_i.pwrite && !req_i.pprot[icm_pkg::PRIV_BIT])
      begin
        next_pslverr = 1'b1;
      end
    end
    else if (!ro_hit)
    begin
      next_pslverr = 1'b1;
    end
  end

  // Read data and error flags are held from setup through the access cycle.
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      prdata_o  <= '0;
      pslverr_o <= 1'b0;
    end
    else if (setup_phase)
    begin
      prdata_o  <= req_i.pwrite ? '0 : next_prdata;
      pslverr_o <= next_pslverr;
    end
    else if (!access_fire)
    begin
      pslverr_o <= 1'b0;
    end
  end

  // OR together every requesting input routed to each channel.
  always_comb
  begin
    next_channel_req = '0;
    for (int i = 0; i < icm_pkg::NUM_IN; i++)
    begin
      if (periph_req_i[i])
      begin
        next_channel_req[route_sel[i]] = 1'b1;
      end
    end
  end

  // Channel outputs follow inputs and selectors one cycle later.
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      channel_req_out_o <= '0;
    end
    else
    begin
      channel_req_out_o <= next_channel_req;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      input_pending_flags_o <= '0;
    end
    else
    begin
      input_pending_flags_o <= periph_req_i;
    end
  end

endmodule

`default_nettype wire

// ---- icm_periph_model.sv ----
// Peripheral side model that holds level requests into the mapper.
`default_nettype none

module icm_periph_model (
  // Clock and reset.
  input  wire logic        clock_i,
  input  wire logic        reset_n_i,
  // Wanted and driven request levels.
  input  wire logic [18:0] want_i,
  output logic      [18:0] req_o
);
  // Each peripheral holds its level until the bench withdraws it.
  always_ff @(posedge clock_i or negedge reset_n_i)
    if (!reset_n_i)
      req_o <= '0;
    else
      req_o <= want_i;
endmodule

`default_nettype wire

// ---- icm_checker_assertions.sv ----
// Port checker of the interrupt channel mapper.
`default_nettype none

module icm_checker_assertions (
  // Clock, reset and bus.
  input  wire logic                       clock_i,
  input  wire logic                       reset_n_i,
  input  wire logic                       psel_i,
  input  wire logic                       penable_i,
  input  wire icm_pkg::icm_apb_req_t      req_i,
  input  wire logic [icm_pkg::DATA_W-1:0] prdata_o,
  input  wire logic                       pready_o,
  input  wire logic                       pslverr_o,
  // Requests and channels.
  input  wire logic [icm_pkg::NUM_IN-1:0] periph_req_i,
  input  wire logic [icm_pkg::NUM_CH-1:0] channel_req_out_o,
  input  wire logic [icm_pkg::NUM_IN-1:0] input_pending_flags_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  logic acc;
  logic rt;
  // Access cycle, and whether it targets a routing word.
  assign acc = psel_i && penable_i && pready_o;
  assign rt = req_i.paddr inside {[12'h028:12'h038]};
  property p_unpriv; acc && req_i.pwrite && rt && !req_i.pprot[0]
    |-> pslverr_o; endproperty
  a_unpriv: assert property (p_unpriv)
    else $error("unprivileged write accepted");
  property p_priv; acc && req_i.pwrite && rt && req_i.pprot[0]
    && req_i.paddr[1:0] == 2'h0 |-> !pslverr_o; endproperty
  a_priv: assert property (p_priv)
    else $error("privileged write refused");
  property p_rsv; acc && !req_i.pwrite && rt
    |-> (prdata_o & 32'he0e0e0e0) == 32'h0; endproperty
  a_rsv: assert property (p_rsv)
    else $error("reserved bits set");
  property p_word2; acc && !req_i.pwrite && req_i.paddr == 12'h028
    |-> prdata_o[28:24] == 5'h00; endproperty
  a_word2: assert property (p_word2)
    else $error("uncovered lane not zero");
  property p_pend; input_pending_flags_o == $past(periph_req_i); endproperty
  a_pend: assert property (p_pend)
    else $error("pending flags wrong");
  property p_idle; $past(periph_req_i) == '0 |-> channel_req_out_o == '0;
  endproperty
  a_idle: assert property (p_idle)
    else $error("channel without request");
  property p_any; $past(periph_req_i) != '0 |-> channel_req_out_o != '0;
  endproperty
  a_any: assert property (p_any)
    else $error("request reached no channel");
  property p_count; $countones(channel_req_out_o)
    <= $countones($past(periph_req_i)); endproperty
  a_count: assert property (p_count)
    else $error("more channels than requests");
  c_wr: cover property (acc && req_i.pwrite && req_i.pprot[0]);
  c_err: cover property (acc && pslverr_o);
  c_ch: cover property (channel_req_out_o[31]);
endmodule

bind icm_interrupt_channel_mapper icm_checker_assertions i_icm_checker (
  .clock_i(clock_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
  .penable_i(penable_i), .req_i(req_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .periph_req_i(periph_req_i),
  .channel_req_out_o(channel_req_out_o),
  .input_pending_flags_o(input_pending_flags_o));

`default_nettype wire

// ---- icm_interrupt_channel_mapper_bench.sv ----
// Bench for the interrupt channel mapper.
`default_nettype none

module icm_interrupt_channel_mapper_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  clock_i, reset_n_i, psel, pen, pready, er;
  logic [31:0]           prdata, chan, rd, e;
  logic [18:0]           want, preq, pend;
  logic                  perr;
  icm_pkg::icm_apb_req_t req;
  int                    bad_count, check_count, cyc, w, l, n;

  icm_periph_model i_icm_periph_model (.clock_i(clock_i),
    .reset_n_i(reset_n_i), .want_i(want), .req_o(preq));
  icm_interrupt_channel_mapper i_icm_interrupt_channel_mapper (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .psel_i(psel),
    .penable_i(pen), .req_i(req), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(perr), .periph_req_i(preq), .channel_req_out_o(chan),
    .input_pending_flags_o(pend));

  // Prints the verdict and stops.
  task end_sim;
    if (bad_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Compares one value with its expectation.
  task chk(input logic [31:0] s, input logic [31:0] x);
    check_count++;
    if (s !== x)
    begin
      bad_count++;
      $display("BAD %0t %h %h", $time, s, x);
    end
  endtask

  // One APB transfer; read data and error are taken at the ready edge.
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
           input logic [3:0] s, input logic [2:0] p);
    @(posedge clock_i);
    psel <= 1'b1;
    req <= '{a, wr, d, s, p};
    @(posedge clock_i);
    pen <= 1'b1;
    do @(posedge clock_i); while (pready !== 1'b1);
    rd = prdata;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  // Clock at 125 MHz.
  initial
  begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  // Cuts a hang short.
  always @(posedge clock_i)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      bad_count++;
      end_sim;
    end
  end

  // Main sequence.
  initial
  begin
    reset_n_i = 1'b0;
    psel = 1'b0;
    pen = 1'b0;
    req = '0;
    want = '0;
    repeat (6) @(posedge clock_i);
    reset_n_i <= 1'b1;
    // Identity map after reset, four lanes per word.
    for (w = 2; w <= 6; w++)
    begin
      apb(1'b0, 12'h020 + 12'(4 * w), 32'h0, 4'h0, 3'h1);
      e = '0;
      for (l = 0; l < 4; l++)
      begin
        n = 4 * w + 3 - l;
        if (n >= 9) e[8*l+:5] = n[4:0];
      end
      chk(rd, e);
    end
    apb(1'b1, 12'h02c, 32'h0, 4'hf, 3'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b0, 12'h02c, 32'h0, 4'h0, 3'h1);
    chk(rd, 32'h0c0d0e0f);
    apb(1'b1, 12'h030, 32'hffffffff, 4'h2, 3'h1);
    chk({31'h0, er}, 32'h0);
    apb(1'b0, 12'h030, 32'h0, 4'h0, 3'h1);
    chk(rd, 32'h10111f13);
    apb(1'b1, 12'h030, 32'h0, 4'h1, 3'h1);
    @(posedge clock_i);
    want <= 19'h00600;
    repeat (3) @(posedge clock_i);
    chk(chan, 32'h80000001);
    chk({13'h0, pend}, 32'h600);
    apb(1'b0, 12'h000, 32'h0, 4'h0, 3'h1);
    chk(rd, 32'h000c0000);
    apb(1'b0, 12'h010, 32'h0, 4'h0, 3'h1);
    chk(rd, 32'h80000001);
    // A reset in mid-run brings back the identity map.
    @(posedge clock_i);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    reset_n_i <= 1'b1;
    apb(1'b0, 12'h030, 32'h0, 4'h0, 3'h1);
    chk(rd, 32'h10111213);
    repeat (2) @(posedge clock_i);
    chk(chan, 32'h000c0000);
    apb(1'b0, 12'hffc, 32'h0, 4'h0, 3'h1);
    chk({31'h0, er}, 32'h1);
    end_sim;
  end
endmodule

`default_nettype wire
